// >>> common/operating_mode_code_strap_map.vh
// register map and field layout of the operating mode strap block
// assumes inclusion by name from src files; definitions only
`ifndef OPERATING_MODE_CODE_STRAP_MAP_VH
`define OPERATING_MODE_CODE_STRAP_MAP_VH

// extended register indices; byte address is four times the index
`define STRAP_STATUS_IDX      9'h06e
`define OPERATING_MODE_CODE_CONFIG_IDX     9'h1df
`define REG_ADDR_W            11

// field layout
`define MODE_CODE_LSB         0
`define MODE_CODE_MSB         2
`define CFG_OVERRIDE_BIT      15
`define CONFIG_RESET          16'h0000
`define UNMAPPED_READ         32'h0000_0000

// mode codes
`define MODE_RGMII_COPPER     3'h0
`define MODE_RGMII_1000X      3'h1
`define MODE_RGMII_100FX      3'h2
`define MODE_RGMII_SGMII      3'h3
`define MODE_1000T_1000X      3'h4
`define MODE_100TX_100FX      3'h5
`define MODE_SGMII_COPPER     3'h6
`define MODE_BOUNDARY_SCAN    3'h7

`endif

// >>> sim/operating_mode_strap_select_tb.sv
// self-checking bench for the strap select block
// assumes one 10 MHz clock and the strap board model
`timescale 1ns/1ps
module operating_mode_strap_select_tb;
    localparam logic [2:0] STRAP = 3'h6;
    logic i_clock = 0, i_rst = 1, i_avs_read = 0, i_avs_write = 0;
    logic [10:0] i_avs_address = 11'h000;
    logic [31:0] i_avs_writedata = 32'h0000_0000, rd;
    logic [3:0]  i_avs_byteenable = 4'hf;
    logic [2:0]  strap_code = STRAP;
    wire         i_gpio1_strap, i_receive_bit3_pin, i_receive_bit2_pin, o_avs_waitrequest;
    wire [31:0]  o_avs_readdata;
    wire [2:0]   o_operating_mode_code;
    wire [7:0]   o_mode_onehot;
    int          error_cnt = 0, comparisons = 0;
    always #50 i_clock = ~i_clock;
    strap_board board_u (.i_code(strap_code), .o_gpio1(i_gpio1_strap), .o_bit3(i_receive_bit3_pin), .o_bit2(i_receive_bit2_pin));
    operating_mode_strap_select dut_u (.*);
    task automatic chk(input logic [31:0] s, e, input string nm);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic acc(input bit w, input logic [10:0] a, input logic [31:0] d);
        i_avs_address <= a; i_avs_writedata <= d; i_avs_write <= w; i_avs_read <= !w;
        do @(posedge i_clock); while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_read <= 1'b0; i_avs_write <= 1'b0;
        @(posedge i_clock);
    endtask
    task t_strap;
        // board logic may drive the shared pins once boot is over; latched code must not follow
        strap_code <= 3'h1;
        acc(0, 11'h1b8, 32'h0000_0000); chk(rd, {29'h0, STRAP}, "status");
        chk(o_operating_mode_code, STRAP, "strap mode");
        acc(1, 11'h1b8, 32'h0000_ffff); acc(0, 11'h1b8, 32'h0000_0000);
        chk(rd, {29'h0, STRAP}, "status after write");
        chk(o_operating_mode_code, STRAP, "mode after write");
        acc(0, 11'h004, 32'h0000_0000); chk(rd, 32'h0000_0000, "unmapped");
        $display("strap test done");
    endtask
    task t_cfg;
        for (int i = 0; i < 8; i++) begin
            // mode-specific follow-up writes are software's job and lie outside this block
            acc(1, 11'h77c, 32'h0000_7ff8 | i); chk(o_operating_mode_code, i, "mode");
            chk(o_mode_onehot, 32'h0000_0001 << i, "onehot");
            acc(0, 11'h77c, 32'h0000_0000); chk(rd, 32'h0000_fff8 | i, "config");
        end
        acc(0, 11'h1b8, 32'h0000_0000); chk(rd, {29'h0, STRAP}, "status kept");
        $display("config test done");
    endtask
    task test_done;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_clock);
        t_strap;
        t_cfg;
        test_done;
    end
    initial begin
        repeat (500) @(posedge i_clock);
        error_cnt++;
        test_done;
    end
endmodule

// >>> sim/strap_board.sv
// board straps: three resistors setting the boot code
`timescale 1ns/1ps
module strap_board (input wire [2:0] i_code, output wire o_gpio1, o_bit3, o_bit2);
    assign {o_bit2, o_bit3, o_gpio1} = i_code;
endmodule

// >>> sim/strap_monitor.sv
// checker on the strap select ports; bound to the top module
`timescale 1ns/1ps
module strap_monitor (
    input wire        i_clock, i_rst, i_gpio1_strap, i_receive_bit3_pin, i_receive_bit2_pin, i_avs_read, i_avs_write,
    input wire [10:0] i_avs_address,
    input wire [31:0] i_avs_writedata,
    input wire        o_avs_waitrequest,
    input wire [2:0]  o_operating_mode_code,
    input wire [7:0]  o_mode_onehot);
    wire cfg_hit = i_avs_write && i_avs_address == 11'h77c;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence cfg_taken; cfg_hit && o_avs_waitrequest; endsequence
    onehot_decode_a: assert property (o_mode_onehot == 8'h01 << o_operating_mode_code) else $error("bad onehot");
    status_ro_a: assert property (i_avs_write && i_avs_address == 11'h1b8 |=> ##1 $stable(o_operating_mode_code))
        else $error("status write moved mode");
    cfg_apply_a: assert property (cfg_taken |=> ##1 o_operating_mode_code == $past(i_avs_writedata[2:0], 2))
        else $error("config not applied");
    strap_latch_a:
        assert property ($fell(i_rst) |=> ##1 o_operating_mode_code == {i_receive_bit2_pin, i_receive_bit3_pin, i_gpio1_strap})
        else $error("straps not latched");
    one_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("no answer");
    wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("long answer");
    mode_hold_a: assert property ($changed(o_operating_mode_code) && !$past(i_rst, 3) |-> $past(cfg_hit, 2))
        else $error("mode moved alone");
endmodule
bind operating_mode_strap_select strap_monitor mon_u (.*);

// >>> src/operating_mode_strap_select.v
// operating mode selection from three boot straps with software override
// assumes straps synchronous to i_clock and stable while reset is released;
// registers reached as extended space over an avalon-mm slave port
//
// Overview of operation
// - three straps form the mode code
// - mode code decodes to eight modes
// - latched strap code readable in status register
// - status register ignores writes entirely
// - config write overrides strapped mode code
// - both registers live in extended space
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "operating_mode_code_strap_map.vh"

module operating_mode_strap_select (
    input  wire                   i_clock,
    input  wire                   i_rst,
    input  wire                   i_gpio1_strap,
    input  wire                   i_receive_bit3_pin,
    input  wire                   i_receive_bit2_pin,
    input  wire [`REG_ADDR_W-1:0] i_avs_address,
    input  wire                   i_avs_read,
    input  wire                   i_avs_write,
    input  wire [31:0]            i_avs_writedata,
    input  wire [3:0]             i_avs_byteenable,
    output reg  [31:0]            o_avs_readdata,
    output reg                    o_avs_waitrequest,
    output reg  [2:0]             o_operating_mode_code,
    output reg  [7:0]             o_mode_onehot
);

    reg        latch_pending_r;
    reg [2:0]  strap_code_r;
    reg [15:0] config_r;
    reg        done_r;

    wire [2:0] strap_raw;
    wire [8:0] word_idx;
    wire       is_status;
    wire       is_config;
    wire       req;
    reg  [2:0] mode_nxt;
    reg  [7:0] onehot_nxt;
    reg [31:0] rdata_nxt;
    reg [15:0] config_nxt;

    assign strap_raw = {i_receive_bit2_pin, i_receive_bit3_pin, i_gpio1_strap};
    assign word_idx  = i_avs_address[10:2];
    // extended space only: nothing else in this block is addressable
    assign is_status = (word_idx == `STRAP_STATUS_IDX);
    assign is_config = (word_idx == `OPERATING_MODE_CODE_CONFIG_IDX);
    assign req       = (i_avs_read | i_avs_write) & ~done_r;

    // first clock after release takes the straps; board must not drive them
    always @(posedge i_clock) begin
        if (i_rst) begin
            latch_pending_r <= 1'b1;
            strap_code_r    <= 3'h0;
        end else if (latch_pending_r) begin
            latch_pending_r <= 1'b0;
            strap_code_r    <= strap_raw;
        end
    end

    always @* begin
        config_nxt = config_r;
        if (req && i_avs_write && is_config) begin
            if (i_avs_byteenable[0])
                config_nxt[7:0] = i_avs_writedata[7:0];
            if (i_avs_byteenable[1])
                config_nxt[15:8] = i_avs_writedata[15:8];
            // any config write arms the override, so software need not know bit 15
            config_nxt[`CFG_OVERRIDE_BIT] = 1'b1;
        end
    end

    always @* begin
        if (config_r[`CFG_OVERRIDE_BIT])
            mode_nxt = config_r[`MODE_CODE_MSB:`MODE_CODE_LSB];
        else if (latch_pending_r)
            mode_nxt = strap_raw;
        else
            mode_nxt = strap_code_r;
    end

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_decode
            // genvar cannot be part-selected; a sized copy keeps the compare 3 bits wide
            localparam [2:0] dec_code = g;
            always @* begin
                onehot_nxt[g] = (mode_nxt == dec_code);
            end
        end
    endgenerate

    always @* begin
        rdata_nxt = `UNMAPPED_READ;
        if (is_status)
            rdata_nxt = {29'h0000_0000, strap_code_r};
        else if (is_config)
            rdata_nxt = {16'h0000, config_r};
    end

    // one wait cycle per access so read data come from a flip-flop
    always @(posedge i_clock) begin
        if (i_rst) begin
            config_r              <= `CONFIG_RESET;
            done_r                <= 1'b0;
            o_avs_waitrequest     <= 1'b1;
            o_avs_readdata        <= `UNMAPPED_READ;
            o_operating_mode_code <= `MODE_RGMII_COPPER;
            o_mode_onehot         <= 8'h01;
        end else begin
            // writes to the status index fall through untouched
            config_r              <= config_nxt;
            done_r                <= req;
            o_avs_waitrequest     <= ~req;
            o_operating_mode_code <= mode_nxt;
            o_mode_onehot         <= onehot_nxt;
            if (req && i_avs_read)
                o_avs_readdata <= rdata_nxt;
        end
    end

endmodule
